// *** inc/pot_pkg.sv ***
package pot_pkg;

    // ------------------------------------------------------------
    // Frame and field layout
    // ------------------------------------------------------------
    localparam int WORD_W   = 24;
    localparam int CMD_W    = 4;
    localparam int ADDR_W   = 4;
    localparam int WIPER_W  = 10;
    localparam int CMD_POS  = 20;
    localparam int ADDR_POS = 16;
    localparam int CNT_W    = 5;
    localparam logic [CNT_W-1:0] FRAME_BITS = 5'h18;

    // ------------------------------------------------------------
    // Commands and channel addresses
    // ------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_NOP         = 4'h0;
    localparam logic [CMD_W-1:0] CMD_NV_READ     = 4'h1;
    localparam logic [CMD_W-1:0] CMD_STORE       = 4'h2;
    localparam logic [CMD_W-1:0] CMD_NV_WRITE    = 4'h3;
    localparam logic [CMD_W-1:0] CMD_RELOAD_ALL  = 4'h8;
    localparam logic [CMD_W-1:0] CMD_RB_NV       = 4'h9;
    localparam logic [CMD_W-1:0] CMD_RB_WIPER    = 4'ha;
    localparam logic [CMD_W-1:0] CMD_WIPER_WRITE = 4'hb;
    localparam logic [ADDR_W-1:0] ADDR_CH_ONE    = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CH_TWO    = 4'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [WIPER_W-1:0] MIDSCALE = 10'h200;
    localparam logic [WORD_W-1:0]  WORD_RST = 24'h000000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ     = 250;
    localparam int T_RELOAD_US = 1000;
    localparam int T_READ_US   = 100;
    localparam int T_STORE_US  = 20000;
    localparam int T_PRESET_US = 140;
    localparam int RELOAD_CYC  = T_RELOAD_US * CLK_MHZ;
    localparam int READ_CYC    = T_READ_US * CLK_MHZ;
    localparam int STORE_CYC   = T_STORE_US * CLK_MHZ;
    localparam int PRESET_CYC  = T_PRESET_US * CLK_MHZ;
    localparam int BUSY_W      = 23;
    localparam int FIFO_DEPTH  = 32;

endpackage

// *** inc/link_if.sv ***
`timescale 1ns/10ps
// Words passing between the serial-clock side and the system side
interface link_if;
    import pot_pkg::*;
    logic [WORD_W-1:0] rx_word;
    logic              rx_full;
    logic              rb_valid;
    logic [WORD_W-1:0] rb_word;
    modport link (output rx_word, output rx_full, input rb_valid, input rb_word);
    modport core (input rx_word, input rx_full, output rb_valid, output rb_word);
endinterface

// *** src/pot_fifo.sv ***
`timescale 1ns/10ps
module pot_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      fill_ff;

    // Honest flags straight from the fill count
    wire push_w = in_valid & in_ready;
    wire pop_w  = out_valid & out_ready;
    assign in_ready  = (fill_ff != (AW+1)'(DEPTH));
    assign out_valid = (fill_ff != '0);
    assign out_data  = mem_ff[rd_ff];

    // Storage written at the write index
    always_ff @(posedge clk)
    begin
        if (push_w)
            mem_ff[wr_ff] <= in_data;
    end

    // Pointers wrap at the depth
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ff   <= '0;
            rd_ff   <= '0;
            fill_ff <= '0;
        end
        else
        begin
            if (push_w)
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            if (pop_w)
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            fill_ff <= fill_ff + (AW+1)'(push_w) - (AW+1)'(pop_w);
        end
    end
endmodule

// *** src/pot_link.sv ***
`timescale 1ns/10ps
module pot_link (
    input  wire logic sclk,
    input  wire logic rst_n,
    input  wire logic cs_n,
    input  wire logic serial_in,
    output logic      serial_out,
    link_if.link      lk
);
    import pot_pkg::*;

    logic [WORD_W-1:0] rx_ff;
    logic [WORD_W-1:0] tx_ff;
    logic [CNT_W-1:0]  cnt_ff;
    logic              start_ff;

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    // MSB first capture
    wire [WORD_W-1:0] nxt_rx  = {rx_ff[WORD_W-2:0], serial_in};
    wire [WORD_W-1:0] nxt_tx  = start_ff ? (lk.rb_valid ? lk.rb_word : rx_ff)
                                         : {tx_ff[WORD_W-2:0], 1'b0};
    wire [CNT_W-1:0]  nxt_cnt = start_ff ? 5'h01
                              : (cnt_ff == FRAME_BITS) ? cnt_ff : cnt_ff + 1'b1;

    assign serial_out = tx_ff[WORD_W-1];
    assign lk.rx_word = rx_ff;
    // Short frames are dropped by the core
    assign lk.rx_full = (cnt_ff == FRAME_BITS);

    // First-edge marker, rearmed by deselect since the clock stops
    always_ff @(posedge sclk or negedge rst_n or posedge cs_n)
    begin
        if (!rst_n)
            start_ff <= 1'b1;
        else if (cs_n)
            start_ff <= 1'b1;
        else
            start_ff <= 1'b0;
    end

    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_ff  <= WORD_RST;
            tx_ff  <= WORD_RST;
            cnt_ff <= '0;
        end
        else if (!cs_n)
        begin
            rx_ff  <= nxt_rx;
            tx_ff  <= nxt_tx;
            cnt_ff <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_shift_msb_first: assert property (@(posedge sclk) disable iff (!rst_n)
        !cs_n |=> rx_ff[0] == $past(serial_in) && rx_ff[WORD_W-1:1] == $past(rx_ff[WORD_W-2:0]))
        else $error("serial input not shifted in msb first");
    a_daisy_chain_out: assert property (@(posedge sclk) disable iff (!rst_n)
        !cs_n && start_ff && !lk.rb_valid |=> serial_out == $past(rx_ff[WORD_W-1]))
        else $error("previous word not passed on");
    a_readback_out: assert property (@(posedge sclk) disable iff (!rst_n)
        !cs_n && start_ff && lk.rb_valid |=> tx_ff == $past(lk.rb_word))
        else $error("readback word not loaded");
endmodule

// *** src/dual_pot_serial_control_port.sv ***
// Function
// - Capture serial input MSB first on rising clock
// - Execute command only when select rises
// - Readback commands drive data next frame
// - Other commands pass previous word onward
// - Address zero selects channel one wiper
// - Address one selects channel two wiper
// - Lock blocks changes except reloads and preset
// - Reload commands still work while locked
// - Preset rising edge reloads wipers from storage
// - Storage holds midscale until first store
// - Open-drain ready marks long operation completion
// - Ready low 1ms, 0.1ms, 0.14ms or 20ms
`timescale 1ns/10ps
module dual_pot_serial_control_port #(
    parameter int RELOAD_CYCLES = pot_pkg::RELOAD_CYC,
    parameter int READ_CYCLES   = pot_pkg::READ_CYC,
    parameter int STORE_CYCLES  = pot_pkg::STORE_CYC,
    parameter int PRESET_CYCLES = pot_pkg::PRESET_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   serial_in,
    output logic                        serial_out,
    input  wire logic                   store_lock_n,
    input  wire logic                   preset_reload_n,
    output logic                        ready_out,
    output logic                        ready_oe_n,
    output logic [pot_pkg::WIPER_W-1:0] wiper_one,
    output logic [pot_pkg::WIPER_W-1:0] wiper_two
);
    import pot_pkg::*;

    typedef enum logic {ST_IDLE, ST_BUSY} exec_state_t;

    link_if lk ();

    // ------------------------------------------------------------
    // Serial-clock side and command queue
    // ------------------------------------------------------------
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    logic              cap_valid_ff;
    logic [WORD_W-1:0] cap_word_ff;
    logic              pop_ready_w;

    pot_link u_link (
        .sclk       (sclk),
        .rst_n      (rst_n),
        .cs_n       (cs_n),
        .serial_in  (serial_in),
        .serial_out (serial_out),
        .lk         (lk)
    );

    pot_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_valid  (cap_valid_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (cap_word_ff),
        .out_valid (fifo_out_valid),
        .out_ready (pop_ready_w),
        .out_data  (fifo_out_data)
    );

    // ------------------------------------------------------------
    // Pin synchronisers: select, lock, preset
    // ------------------------------------------------------------
    logic [2:0] pin_meta_ff;
    logic [2:0] pin_sync_ff;
    logic       cs_prev_ff;
    logic       preset_prev_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_ff <= 3'h7;
            pin_sync_ff <= 3'h7;
            cs_prev_ff     <= 1'b1;
            preset_prev_ff <= 1'b1;
        end
        else
        begin
            pin_meta_ff <= {preset_reload_n, store_lock_n, cs_n};
            pin_sync_ff <= pin_meta_ff;
            cs_prev_ff     <= pin_sync_ff[0];
            preset_prev_ff <= pin_sync_ff[2];
        end
    end

    wire cs_rise_w  = pin_sync_ff[0] & ~cs_prev_ff;
    // Lock high means changes are allowed
    wire wr_ok_w    = pin_sync_ff[1];
    wire preset_rise_w = pin_sync_ff[2] & ~preset_prev_ff;
    // Link words are quiet here: the serial clock stopped with the frame
    wire frame_take = cs_rise_w & lk.rx_full;

    // Held word stalls until the queue has room; set wins over clear
    wire nxt_cap_valid = frame_take | (cap_valid_ff & ~fifo_in_ready);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_valid_ff <= 1'b0;
            cap_word_ff  <= WORD_RST;
        end
        else
        begin
            cap_valid_ff <= nxt_cap_valid;
            if (frame_take)
                cap_word_ff <= lk.rx_word;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    exec_state_t        state_ff;
    logic [BUSY_W-1:0]  busy_cnt_ff;
    logic [WIPER_W-1:0] wiper_ff [2];
    logic [WIPER_W-1:0] nv_ff [2];

    assign pop_ready_w = (state_ff == ST_IDLE) & ~preset_rise_w;
    wire fire_w = fifo_out_valid & pop_ready_w;

    wire [CMD_W-1:0]   cmd_w  = fifo_out_data[CMD_POS +: CMD_W];
    wire [ADDR_W-1:0]  addr_w = fifo_out_data[ADDR_POS +: ADDR_W];
    wire [WIPER_W-1:0] data_w = fifo_out_data[WIPER_W-1:0];

    wire is_nv_read   = fire_w & (cmd_w == CMD_NV_READ);
    wire is_store     = fire_w & (cmd_w == CMD_STORE);
    wire is_nv_write  = fire_w & (cmd_w == CMD_NV_WRITE);
    wire is_reload    = fire_w & (cmd_w == CMD_RELOAD_ALL);
    wire is_rb_nv     = fire_w & (cmd_w == CMD_RB_NV);
    wire is_rb_wiper  = fire_w & (cmd_w == CMD_RB_WIPER);
    wire is_wiper_wr  = fire_w & (cmd_w == CMD_WIPER_WRITE);
    wire is_readback  = is_rb_nv | is_rb_wiper;

    wire [1:0] sel_w = {addr_w == ADDR_CH_TWO, addr_w == ADDR_CH_ONE};

    wire store_ok_w   = (is_store | is_nv_write) & wr_ok_w & (|sel_w);
    wire reload_all_w = preset_rise_w | is_reload;

    // ------------------------------------------------------------
    // Per-channel wiper and storage
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++)
        begin : g_chan
            wire hit_w = sel_w[ch];
            wire [WIPER_W-1:0] nxt_wiper =
                (reload_all_w | (is_nv_read & hit_w)) ? nv_ff[ch] :
                (is_wiper_wr & hit_w & wr_ok_w)       ? data_w    : wiper_ff[ch];
            wire [WIPER_W-1:0] nxt_nv =
                (is_store & hit_w & wr_ok_w)    ? wiper_ff[ch] :
                (is_nv_write & hit_w & wr_ok_w) ? data_w       : nv_ff[ch];

            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    wiper_ff[ch] <= MIDSCALE;
                    nv_ff[ch]    <= MIDSCALE;
                end
                else
                begin
                    wiper_ff[ch] <= nxt_wiper;
                    nv_ff[ch]    <= nxt_nv;
                end
            end
        end
    endgenerate

    assign wiper_one = wiper_ff[0];
    assign wiper_two = wiper_ff[1];

    // ------------------------------------------------------------
    // Ready timing
    // ------------------------------------------------------------
    // hold time per operation
    wire [BUSY_W-1:0] load_val_w =
        preset_rise_w ? BUSY_W'(PRESET_CYCLES) :
        is_reload   ? BUSY_W'(RELOAD_CYCLES) :
        is_readback ? BUSY_W'(READ_CYCLES)   : BUSY_W'(STORE_CYCLES);
    wire busy_load_w = preset_rise_w | is_reload | is_readback | store_ok_w;

    exec_state_t      nxt_state;
    logic [BUSY_W-1:0] nxt_busy_cnt;

    // Preset restarts the wait even mid-operation
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_busy_cnt = busy_cnt_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (busy_load_w)
                begin
                    nxt_state    = ST_BUSY;
                    nxt_busy_cnt = load_val_w;
                end
            end
            ST_BUSY:
            begin
                if (preset_rise_w)
                    nxt_busy_cnt = load_val_w;
                else if (busy_cnt_ff <= BUSY_W'(1))
                    nxt_state = ST_IDLE;
                else
                    nxt_busy_cnt = busy_cnt_ff - 1'b1;
            end
            default:
            begin
                nxt_state    = ST_IDLE;
                nxt_busy_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_IDLE;
            busy_cnt_ff <= '0;
            ready_out   <= 1'b1;
            ready_oe_n  <= 1'b1;
        end
        else
        begin
            state_ff    <= nxt_state;
            busy_cnt_ff <= nxt_busy_cnt;
            ready_out   <= (nxt_state == ST_IDLE);
            ready_oe_n  <= (nxt_state == ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Readback word for the next frame
    // ------------------------------------------------------------
    logic              rb_valid_ff;
    logic [WORD_W-1:0] rb_word_ff;

    wire [WIPER_W-1:0] rb_val_w = ~(|sel_w) ? '0 :
        is_rb_nv ? nv_ff[sel_w[1]] : wiper_ff[sel_w[1]];

    // armed by readback, spent by next frame; set wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rb_valid_ff <= 1'b0;
            rb_word_ff  <= WORD_RST;
        end
        else
        begin
            rb_valid_ff <= is_readback | (rb_valid_ff & ~frame_take);
            if (is_readback)
                rb_word_ff <= {cmd_w, addr_w, 6'h00, rb_val_w};
        end
    end

    assign lk.rb_valid = rb_valid_ff;
    assign lk.rb_word  = rb_word_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [BUSY_W-1:0] low_len_ff;
    logic [BUSY_W-1:0] expect_ff;

    // Measures each ready-low stretch against its loaded length
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_len_ff <= '0;
            expect_ff  <= '0;
        end
        else if (busy_load_w)
        begin
            low_len_ff <= '0;
            expect_ff  <= load_val_w;
        end
        else if (!ready_out)
            low_len_ff <= low_len_ff + 1'b1;
    end

    a_push_on_cs_rise: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cap_valid_ff) |-> $past(cs_rise_w) && pin_sync_ff[0])
        else $error("command queued without select rise");
    a_chan_one_write: assert property (@(posedge clk) disable iff (!rst_n)
        is_wiper_wr && wr_ok_w && addr_w == ADDR_CH_ONE && !preset_rise_w
        |=> wiper_one == $past(data_w) && $stable(wiper_two))
        else $error("address zero did not write channel one");
    a_chan_two_write: assert property (@(posedge clk) disable iff (!rst_n)
        is_wiper_wr && wr_ok_w && addr_w == ADDR_CH_TWO && !preset_rise_w
        |=> wiper_two == $past(data_w) && $stable(wiper_one))
        else $error("address one did not write channel two");
    a_lock_blocks_write: assert property (@(posedge clk) disable iff (!rst_n)
        (is_wiper_wr || is_store || is_nv_write) && !wr_ok_w
        |=> $stable(wiper_one) && $stable(wiper_two) && $stable(nv_ff[0]) && $stable(nv_ff[1]))
        else $error("locked command changed contents");
    a_reload_all_lock: assert property (@(posedge clk) disable iff (!rst_n)
        is_reload |=> wiper_one == $past(nv_ff[0]) && wiper_two == $past(nv_ff[1])
                      ##1 !ready_out)
        else $error("reload all not applied");
    a_preset_reload: assert property (@(posedge clk) disable iff (!rst_n)
        preset_rise_w |=> wiper_one == $past(nv_ff[0]) && wiper_two == $past(nv_ff[1])
                      && !ready_out && !ready_oe_n)
        else $error("preset did not reload wipers");
    a_nv_midscale_rst: assert property (@(posedge clk)
        $rose(rst_n) |-> nv_ff[0] == MIDSCALE && nv_ff[1] == MIDSCALE)
        else $error("storage not at midscale after reset");
    a_ready_open_drain: assert property (@(posedge clk) disable iff (!rst_n)
        ready_out == ready_oe_n && (ready_out == (state_ff == ST_IDLE)))
        else $error("ready pin does not follow busy state");
    a_ready_low_width: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(ready_out) |-> low_len_ff == expect_ff)
        else $error("ready low time wrong");
    a_readback_armed: assert property (@(posedge clk) disable iff (!rst_n)
        is_readback |=> rb_valid_ff [*2])
        else $error("readback not armed for next frame");

    c_readback: cover property (@(posedge clk) disable iff (!rst_n)
        is_rb_wiper ##[1:1000] frame_take);
    c_preset: cover property (@(posedge clk) disable iff (!rst_n) preset_rise_w);
    c_locked_store: cover property (@(posedge clk) disable iff (!rst_n)
        is_store && !wr_ok_w);
    c_queue_full: cover property (@(posedge clk) disable iff (!rst_n)
        cap_valid_ff && !fifo_in_ready);
endmodule

// *** bench/spi_host.sv ***
`timescale 1ns/10ps
module spi_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      serial_in,
    input  wire logic serial_out
);
    // ----------------------------------------
    // Host frame driver
    // ----------------------------------------
    // Clock idles low, select idles high
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        serial_in = 1'b0;
    end

    // MSB first, rising edge
    // Sample the answer once the falling edge has passed
    task automatic xfer(input logic [23:0] w, input bit sel, output logic [23:0] r);
        cs_n = !sel;
        #11; // Odd offset keeps link edges off the system clock edges
        for (int i = 23; i >= 0; i--)
        begin
            serial_in = w[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
            r[i] = serial_out;
        end
        #16 cs_n = 1'b1;
        // Released line must not keep its last value
        serial_in = ~serial_in;
    endtask
endmodule

// *** bench/test_dual_pot_serial_control_port.sv ***
`timescale 1ns/10ps
module test_dual_pot_serial_control_port;
    import pot_pkg::*;
    localparam int RLD = 20, RD = 8, ST = 40, PST = 12;
    logic              clk, rst_n, sclk, cs_n, serial_in, serial_out;
    logic              store_lock_n, preset_reload_n, ready_out, ready_oe_n;
    logic [WIPER_W-1:0] wiper_one, wiper_two;
    logic [23:0]       rx, out_exp;
    int                nv[2], wp[2], n_mismatch, num_checks, seed;

    // ----------------------------------------
    // Device, host and clock
    // ----------------------------------------
    dual_pot_serial_control_port #(.RELOAD_CYCLES(RLD), .READ_CYCLES(RD),
        .STORE_CYCLES(ST), .PRESET_CYCLES(PST)) uut (.clk(clk), .rst_n(rst_n),
        .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
        .store_lock_n(store_lock_n), .preset_reload_n(preset_reload_n),
        .ready_out(ready_out), .ready_oe_n(ready_oe_n), .wiper_one(wiper_one),
        .wiper_two(wiper_two));
    spi_host host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
        .serial_out(serial_out));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Bounded wait for the low pulse, then count its length
    task automatic wait_ready(input int n);
        int k;
        k = 0;
        for (int i = 0; i < 12 && ready_out !== 1'b0; i++)
            @(negedge clk);
        chk("ready_oe_n", 24'(n == 0), 24'(ready_oe_n));
        while (ready_out === 1'b0 && k < 100)
        begin
            k++;
            @(negedge clk);
        end
        chk("ready_low", 24'(n), 24'(k));
        chk("wiper_one", 24'(wp[0]), 24'(wiper_one));
        chk("wiper_two", 24'(wp[1]), 24'(wiper_two));
    endtask

    // One frame; model acts only after the frame is over
    task automatic send(input int c, input int a, input int d, input int busy);
        logic [23:0] w;
        bit          ok;
        w = {c[3:0], a[3:0], 6'h00, d[9:0]};
        ok = a < 2;
        host.xfer(w, 1'b1, rx);
        chk("serial_out", out_exp, rx);
        out_exp = w;
        case (c)
            1: if (ok) wp[a] = nv[a];
            2: if (ok && store_lock_n) nv[a] = wp[a];
            3: if (ok && store_lock_n) nv[a] = d;
            8: wp = nv;
            9: out_exp[9:0] = ok ? 10'(nv[a]) : 10'h000;
            10: out_exp[9:0] = ok ? 10'(wp[a]) : 10'h000;
            11: if (ok && store_lock_n) wp[a] = d;
            default: ;
        endcase
        wait_ready(busy);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        store_lock_n = 1'b1;
        preset_reload_n = 1'b1;
        n_mismatch = 0;
        num_checks = 0;
        out_exp = 24'h000000;
        nv = '{512, 512};
        wp = nv;
        seed = $urandom(14915);
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        host.xfer(24'hb003ff, 1'b0, rx);
        wait_ready(0);
        send(9, 0, 0, RD);
        for (int i = 0; i < 5; i++)
            send(11, i % 3, $urandom % 1024, 0);
        send(2, 0, 0, ST);
        send(3, 1, $urandom % 1024, ST);
        send(11, 1, $urandom % 1024, 0);
        send(1, 1, 0, 0);
        send(0, 0, 0, 0);
        send(10, 0, 0, RD);
        send(9, 1, 0, RD);
        send(8, 0, 0, RLD);
        @(negedge clk);
        store_lock_n = 1'b0;
        repeat (4) @(negedge clk);
        send(11, 0, $urandom % 1024, 0);
        send(2, 0, 0, 0);
        send(3, 1, $urandom % 1024, 0);
        send(1, 0, 0, 0);
        send(8, 0, 0, RLD);
        send(0, 0, 0, 0);
        store_lock_n = 1'b1;
        repeat (4) @(negedge clk);
        send(11, 0, $urandom % 1024, 0);
        send(11, 1, $urandom % 1024, 0);
        preset_reload_n = 1'b0;
        repeat (4) @(negedge clk);
        chk("wiper_hold", 24'(wp[0]), 24'(wiper_one));
        preset_reload_n = 1'b1;
        wp = nv;
        wait_ready(PST);
        send(0, 0, 0, 0);
        report_and_stop;
    end

    // Whole run is about 20 us; cut a hang well beyond that
    initial
    begin
        #300000;
        n_mismatch++;
        report_and_stop;
    end
endmodule
